// [src/ures_top.v]
// Two-port receive error status block with AXI4-Lite registers and timer prescaler
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ures_regs.vh"
module ures_top (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        ARST_N,
    // Serial receive lines
    input  wire        RX_LINE_0,
    input  wire        RX_LINE_1,
    // AXI4-Lite write address
    input  wire [12:0] S_AXI_AWADDR,
    input  wire [2:0]  S_AXI_AWPROT,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    // AXI4-Lite write response
    output wire [1:0]  S_AXI_BRESP,
    output wire        S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire [12:0] S_AXI_ARADDR,
    input  wire [2:0]  S_AXI_ARPROT,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    // AXI4-Lite read data
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0]  S_AXI_RRESP,
    output wire        S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    // Interrupts and timer clock enable
    output wire        RX_INT_0,
    output wire        RX_INT_1,
    output wire        IRQ,
    output wire        TIMER_TICK
);
    // Bus state
    reg        awready_ff;
    reg        wready_ff;
    reg        aw_got_ff;
    reg        w_got_ff;
    reg [12:0] aw_addr_ff;
    reg [7:0]  w_data_ff;
    reg        w_strb_ff;
    reg        bvalid_ff;
    reg [1:0]  bresp_ff;
    reg        arready_ff;
    reg        rvalid_ff;
    reg [7:0]  rdata_ff;
    reg [1:0]  rresp_ff;

    // Register state
    reg [7:0]  scr_ff;
    reg [7:0]  baud_ff;
    reg [3:0]  mode_ff;
    reg [1:0]  ren_ff;
    reg [1:0]  ri_ff;
    reg [1:0]  fe_ff;
    reg [1:0]  br_ff;
    reg [1:0]  oe_ff;
    reg [1:0]  stint_ff;
    reg [1:0]  rb8_ff;
    reg [15:0] rbuf_ff;
    reg [3:0]  ist_ff;
    reg [3:0]  imask_ff;
    reg [1:0]  rx_int_ff;
    reg        irq_ff;

    // Clock dividers
    reg [5:0]  ps_cnt_ff;
    reg [5:0]  ps_last;
    reg        ps_tick_ff;
    reg [7:0]  baud_cnt_ff;
    reg        var_tick_ff;
    reg        fix_ph_ff;
    reg        fix_tick_ff;

    // Next values
    reg [3:0]  nxt_mode;
    reg [1:0]  nxt_ren;
    reg [1:0]  nxt_ri;
    reg [1:0]  nxt_fe;
    reg [1:0]  nxt_br;
    reg [1:0]  nxt_oe;
    reg [1:0]  nxt_stint;
    reg [1:0]  nxt_rb8;
    reg [15:0] nxt_rbuf;
    reg [3:0]  nxt_ist;

    // Decode results
    reg [1:0]  wsel_ctrl;
    reg [1:0]  wsel_stat;
    reg        wsel_scr;
    reg        wsel_baud;
    reg        wsel_ist;
    reg        wsel_imask;
    reg        wr_map;
    reg        rd_map;
    reg [7:0]  rd_val;

    // Receiver results
    wire [1:0]  rx_done;
    wire [1:0]  rx_stop_bad;
    wire [1:0]  rx_d8;
    wire [1:0]  rx_brk;
    wire [15:0] rx_data;
    wire [1:0]  rx_rb8;
    wire [1:0]  rx_line = {RX_LINE_1, RX_LINE_0};

    wire [10:0] wr_idx  = aw_addr_ff[12:2];
    wire [10:0] rd_idx  = S_AXI_ARADDR[12:2];
    wire        wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire        wr_en   = wr_fire & w_strb_ff;
    wire [7:0]  wd      = w_data_ff;
    wire [1:0]  psel    = scr_ff[`URES_SCR_PS_HI:`URES_SCR_PS_LO];
    wire [3:0]  ev      = {rx_done[1] & rx_stop_bad[1] | rx_brk[1] | rx_d8[1] & ri_ff[1],
                           rx_done[0] & rx_stop_bad[0] | rx_brk[0] | rx_d8[0] & ri_ff[0],
                           rx_done};

    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY  = wready_ff;
    assign S_AXI_BRESP   = bresp_ff;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RDATA   = {24'h00_0000, rdata_ff};
    assign S_AXI_RRESP   = rresp_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign RX_INT_0      = rx_int_ff[0];
    assign RX_INT_1      = rx_int_ff[1];
    assign IRQ           = irq_ff;
    assign TIMER_TICK    = ps_tick_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_port
            ures_rx u_rx (
                .clk        (CORE_CLK),
                .arst_n     (ARST_N),
                .rx_line    (rx_line[gi]),
                .tick16     ((mode_ff[2*gi+1 -: 2] == `URES_MODE_FIX9) ? fix_tick_ff : var_tick_ff),
                .enable     (ren_ff[gi] & (mode_ff[2*gi+1 -: 2] != `URES_MODE_SHIFT)),
                .nine_bit   (mode_ff[2*gi+1]),
                .frame_done (rx_done[gi]),
                .stop_bad   (rx_stop_bad[gi]),
                .data8_seen (rx_d8[gi]),
                .break_hit  (rx_brk[gi]),
                .data       (rx_data[8*gi+7 -: 8]),
                .rb8        (rx_rb8[gi])
            );
        end
    endgenerate

    // Write address decode
    always @*
    begin
        wsel_ctrl  = 2'h0;
        wsel_stat  = 2'h0;
        wsel_scr   = 1'b0;
        wsel_baud  = 1'b0;
        wsel_ist   = 1'b0;
        wsel_imask = 1'b0;
        wr_map     = 1'b1;
        if (wr_idx == `URES_IDX_CTRL0)
            wsel_ctrl[0] = wr_en;
        else if (wr_idx == `URES_IDX_STAT0)
            wsel_stat[0] = wr_en;
        else if (wr_idx == `URES_IDX_CTRL1)
            wsel_ctrl[1] = wr_en;
        else if (wr_idx == `URES_IDX_STAT1)
            wsel_stat[1] = wr_en;
        else if (wr_idx == `URES_IDX_SCR)
            wsel_scr = wr_en;
        else if (wr_idx == `URES_IDX_BAUD)
            wsel_baud = wr_en;
        else if (wr_idx == `URES_IDX_IRQ_STAT)
            wsel_ist = wr_en;
        else if (wr_idx == `URES_IDX_IRQ_MASK)
            wsel_imask = wr_en;
        else if ((wr_idx == `URES_IDX_DATA0) || (wr_idx == `URES_IDX_DATA1))
            wr_map = 1'b1;
        else
            wr_map = 1'b0;
    end

    // Read address decode
    always @*
    begin
        rd_map = 1'b1;
        rd_val = 8'h00;
        if (rd_idx == `URES_IDX_CTRL0)
            rd_val = {3'h0, rb8_ff[0], ri_ff[0], ren_ff[0], mode_ff[1:0]};
        else if (rd_idx == `URES_IDX_STAT0)
            rd_val = {4'h0, fe_ff[0], br_ff[0], oe_ff[0], stint_ff[0]};
        else if (rd_idx == `URES_IDX_DATA0)
            rd_val = rbuf_ff[7:0];
        else if (rd_idx == `URES_IDX_CTRL1)
            rd_val = {3'h0, rb8_ff[1], ri_ff[1], ren_ff[1], mode_ff[3:2]};
        else if (rd_idx == `URES_IDX_STAT1)
            rd_val = {4'h0, fe_ff[1], br_ff[1], oe_ff[1], stint_ff[1]};
        else if (rd_idx == `URES_IDX_DATA1)
            rd_val = rbuf_ff[15:8];
        else if (rd_idx == `URES_IDX_SCR)
            rd_val = scr_ff;
        else if (rd_idx == `URES_IDX_BAUD)
            rd_val = baud_ff;
        else if (rd_idx == `URES_IDX_IRQ_STAT)
            rd_val = {4'h0, ist_ff};
        else if (rd_idx == `URES_IDX_IRQ_MASK)
            rd_val = {4'h0, imask_ff};
        else
            rd_map = 1'b0;
    end

    // Flags: hardware set wins over a software clear in the same cycle
    integer i;
    always @*
    begin
        nxt_mode  = mode_ff;
        nxt_ren   = ren_ff;
        nxt_ri    = ri_ff;
        nxt_fe    = fe_ff;
        nxt_br    = br_ff;
        nxt_oe    = oe_ff;
        nxt_stint = stint_ff;
        nxt_rb8   = rb8_ff;
        nxt_rbuf  = rbuf_ff;
        for (i = 0; i < 2; i = i + 1)
        begin
            if (wsel_ctrl[i])
            begin
                nxt_mode[2*i]   = wd[`URES_CT_MODE_LO];
                nxt_mode[2*i+1] = wd[`URES_CT_MODE_HI];
                nxt_ren[i]      = wd[`URES_CT_REN];
            end
            if (wsel_stat[i])
                nxt_stint[i] = wd[`URES_ST_STINT];
            nxt_ri[i] = rx_done[i] | (ri_ff[i] & ~(wsel_ctrl[i] & ~wd[`URES_CT_RI]));
            nxt_fe[i] = (rx_done[i] & rx_stop_bad[i]) | (fe_ff[i] & ~(wsel_stat[i] & ~wd[`URES_ST_FE]));
            nxt_br[i] = rx_brk[i] | (br_ff[i] & ~(wsel_stat[i] & ~wd[`URES_ST_BR]));
            nxt_oe[i] = (rx_d8[i] & ri_ff[i]) | (oe_ff[i] & ~(wsel_stat[i] & ~wd[`URES_ST_OE]));
            if (rx_done[i])
            begin
                nxt_rb8[i]           = rx_rb8[i];
                nxt_rbuf[8*i+7 -: 8] = rx_data[8*i+7 -: 8];
            end
        end
        nxt_ist = ev | (ist_ff & ~(wsel_ist ? wd[3:0] : 4'h0));
    end

    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mode_ff   <= 4'h0;
            ren_ff    <= 2'h0;
            ri_ff     <= 2'h0;
            fe_ff     <= 2'h0;
            br_ff     <= 2'h0;
            oe_ff     <= 2'h0;
            stint_ff  <= 2'h0;
            rb8_ff    <= 2'h0;
            rbuf_ff   <= 16'h0000;
            ist_ff    <= `URES_IRQ_RST;
            imask_ff  <= `URES_IRQ_RST;
            scr_ff    <= `URES_SCR_RST;
            baud_ff   <= `URES_BAUD_RST;
            rx_int_ff <= 2'h0;
            irq_ff    <= 1'b0;
        end
        else
        begin
            mode_ff   <= nxt_mode;
            ren_ff    <= nxt_ren;
            ri_ff     <= nxt_ri;
            fe_ff     <= nxt_fe;
            br_ff     <= nxt_br;
            oe_ff     <= nxt_oe;
            stint_ff  <= nxt_stint;
            rb8_ff    <= nxt_rb8;
            rbuf_ff   <= nxt_rbuf;
            ist_ff    <= nxt_ist;
            if (wsel_imask)
                imask_ff <= wd[3:0];
            if (wsel_scr)
                scr_ff <= wd;
            if (wsel_baud)
                baud_ff <= wd;
            rx_int_ff <= ri_ff | (stint_ff & (fe_ff | br_ff | oe_ff));
            irq_ff    <= |(ist_ff & imask_ff);
        end
    end

    // Timer clock prescaler
    always @*
    begin
        case (psel)
            `URES_PS_DIV4:  ps_last = `URES_PS_LAST4;
            `URES_PS_DIV16: ps_last = `URES_PS_LAST16;
            default:        ps_last = `URES_PS_LAST64;
        endcase
    end

    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ps_cnt_ff   <= 6'h00;
            ps_tick_ff  <= 1'b0;
            baud_cnt_ff <= 8'h00;
            var_tick_ff <= 1'b0;
            fix_ph_ff   <= 1'b0;
            fix_tick_ff <= 1'b0;
        end
        else
        begin
            fix_ph_ff   <= ~fix_ph_ff;
            fix_tick_ff <= fix_ph_ff;
            var_tick_ff <= 1'b0;
            // Reserved code stops the timer clock
            if (psel == `URES_PS_RESV)
            begin
                ps_cnt_ff  <= 6'h00;
                ps_tick_ff <= 1'b0;
            end
            else if (ps_cnt_ff >= ps_last)
            begin
                ps_cnt_ff  <= 6'h00;
                ps_tick_ff <= 1'b1;
            end
            else
            begin
                ps_cnt_ff  <= ps_cnt_ff + 6'h01;
                ps_tick_ff <= 1'b0;
            end
            // Baud counter overflows from reload to give the 16x tick
            if (ps_tick_ff)
            begin
                if (baud_cnt_ff == `URES_BAUD_TOP)
                begin
                    baud_cnt_ff <= baud_ff;
                    var_tick_ff <= 1'b1;
                end
                else
                    baud_cnt_ff <= baud_cnt_ff + 8'h01;
            end
        end
    end

    // AXI4-Lite write channel
    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            aw_addr_ff <= 13'h0000;
            w_data_ff  <= 8'h00;
            w_strb_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `URES_RESP_OK;
        end
        else
        begin
            if (awready_ff & S_AXI_AWVALID)
            begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= S_AXI_AWADDR;
                awready_ff <= 1'b0;
            end
            else if (~aw_got_ff & ~bvalid_ff)
                awready_ff <= 1'b1;
            if (wready_ff & S_AXI_WVALID)
            begin
                w_got_ff  <= 1'b1;
                w_data_ff <= S_AXI_WDATA[7:0];
                w_strb_ff <= S_AXI_WSTRB[0];
                wready_ff <= 1'b0;
            end
            else if (~w_got_ff & ~bvalid_ff)
                wready_ff <= 1'b1;
            if (wr_fire)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_map ? `URES_RESP_OK : `URES_RESP_SLVERR;
            end
            else if (bvalid_ff & S_AXI_BREADY)
                bvalid_ff <= 1'b0;
        end
    end

    // AXI4-Lite read channel
    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 8'h00;
            rresp_ff   <= `URES_RESP_OK;
        end
        else if (arready_ff & S_AXI_ARVALID)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_val;
            rresp_ff   <= rd_map ? `URES_RESP_OK : `URES_RESP_SLVERR;
        end
        else if (rvalid_ff & S_AXI_RREADY)
            rvalid_ff <= 1'b0;
        else if (~rvalid_ff)
            arready_ff <= 1'b1;
    end
endmodule // ures_top

// [common/ures_regs.vh]
// Register map, field layout and constants for the receive error status block
`ifndef URES_REGS_VH
`define URES_REGS_VH

// Register indexes, byte address is four times the index
`define URES_IDX_CTRL0     11'h420
`define URES_IDX_STAT0     11'h421
`define URES_IDX_DATA0     11'h422
`define URES_IDX_CTRL1     11'h424
`define URES_IDX_STAT1     11'h425
`define URES_IDX_DATA1     11'h426
`define URES_IDX_SCR       11'h440
`define URES_IDX_BAUD      11'h441
`define URES_IDX_IRQ_STAT  11'h442
`define URES_IDX_IRQ_MASK  11'h443

// Status fields
`define URES_ST_FE         3
`define URES_ST_BR         2
`define URES_ST_OE         1
`define URES_ST_STINT      0
// Control fields
`define URES_CT_MODE_LO    0
`define URES_CT_MODE_HI    1
`define URES_CT_REN        2
`define URES_CT_RI         3
`define URES_CT_RB8        4
// System configuration prescaler field
`define URES_SCR_PS_LO     2
`define URES_SCR_PS_HI     3

// Reset values
`define URES_STAT_RST      8'h00
`define URES_CTRL_RST      8'h00
`define URES_SCR_RST       8'h00
`define URES_BAUD_RST      8'h00
`define URES_IRQ_RST       4'h0

// Prescaler codes and last counts
`define URES_PS_DIV4       2'h0
`define URES_PS_DIV16      2'h1
`define URES_PS_DIV64      2'h2
`define URES_PS_RESV       2'h3
`define URES_PS_LAST4      6'h03
`define URES_PS_LAST16     6'h0F
`define URES_PS_LAST64     6'h3F
`define URES_BAUD_TOP      8'hFF

// Serial modes
`define URES_MODE_SHIFT    2'h0
`define URES_MODE_FIX9     2'h2

// Receiver timing in 16x ticks and bit counts
`define URES_MID_TICK      4'h7
`define URES_LAST_TICK     4'hF
`define URES_DATA8_LAST    4'h7
`define URES_DATA9_LAST    4'h8
`define URES_BRK_BITS10    4'h8
`define URES_BRK_BITS11    4'h9
`define URES_RUN_MAX       4'hF

// Bus responses
`define URES_RESP_OK       2'h0
`define URES_RESP_SLVERR   2'h2

`endif

// [src/ures_rx.v]
// Serial receiver with pin filter, framing, overrun hint and break detection
`timescale 1ns/1ns
`include "ures_regs.vh"
module ures_rx (
    // Clock and reset
    input  wire       clk,
    input  wire       arst_n,
    // Line and control
    input  wire       rx_line,
    input  wire       tick16,
    input  wire       enable,
    input  wire       nine_bit,
    // Results
    output reg        frame_done,
    output reg        stop_bad,
    output reg        data8_seen,
    output reg        break_hit,
    output reg  [7:0] data,
    output reg        rb8
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA  = 2'h2;
    localparam ST_STOP  = 2'h3;

    reg       s1_ff;
    reg       s2_ff;
    reg       s3_ff;
    reg       line_ff;
    reg [1:0] state_ff;
    reg [3:0] tick_ff;
    reg [3:0] bitc_ff;
    reg [8:0] shift_ff;
    reg [3:0] run_ff;

    wire [3:0] last_idx = nine_bit ? `URES_DATA9_LAST : `URES_DATA8_LAST;
    wire [3:0] brk_bits = nine_bit ? `URES_BRK_BITS11 : `URES_BRK_BITS10;
    wire       sample   = tick16 & (((state_ff == ST_START) & (tick_ff == `URES_MID_TICK)) |
                          (((state_ff == ST_DATA) | (state_ff == ST_STOP)) & (tick_ff == `URES_LAST_TICK)));

    // Pin filter: level moves once second and third stage agree
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_ff   <= 1'b1;
            s2_ff   <= 1'b1;
            s3_ff   <= 1'b1;
            line_ff <= 1'b1;
        end
        else
        begin
            s1_ff <= rx_line;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
                line_ff <= s3_ff;
        end
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff   <= ST_IDLE;
            tick_ff    <= 4'h0;
            bitc_ff    <= 4'h0;
            shift_ff   <= 9'h000;
            frame_done <= 1'b0;
            stop_bad   <= 1'b0;
            data8_seen <= 1'b0;
            data       <= 8'h00;
            rb8        <= 1'b0;
        end
        else
        begin
            frame_done <= 1'b0;
            stop_bad   <= 1'b0;
            data8_seen <= 1'b0;
            if (!enable)
                state_ff <= ST_IDLE;
            else if (tick16)
            begin
                case (state_ff)
                    ST_IDLE:
                    begin
                        tick_ff <= 4'h0;
                        if (!line_ff)
                            state_ff <= ST_START;
                    end
                    ST_START:
                    begin
                        tick_ff <= tick_ff + 4'h1;
                        if (tick_ff == `URES_MID_TICK)
                        begin
                            tick_ff  <= 4'h0;
                            bitc_ff  <= 4'h0;
                            state_ff <= line_ff ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA:
                    begin
                        tick_ff <= tick_ff + 4'h1;
                        if (tick_ff == `URES_LAST_TICK)
                        begin
                            shift_ff <= {line_ff, shift_ff[8:1]};
                            bitc_ff  <= bitc_ff + 4'h1;
                            if (bitc_ff == `URES_DATA8_LAST)
                                data8_seen <= 1'b1;
                            if (bitc_ff == last_idx)
                                state_ff <= ST_STOP;
                        end
                    end
                    default:
                    begin
                        tick_ff <= tick_ff + 4'h1;
                        if (tick_ff == `URES_LAST_TICK)
                        begin
                            frame_done <= 1'b1;
                            stop_bad   <= ~line_ff;
                            data       <= nine_bit ? shift_ff[7:0] : shift_ff[8:1];
                            rb8        <= nine_bit ? shift_ff[8] : line_ff;
                            state_ff   <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Break: own run counter of low bit samples, start bit counted as bit 1
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            run_ff    <= 4'h0;
            break_hit <= 1'b0;
        end
        else
        begin
            break_hit <= sample & ~line_ff & ((run_ff + 4'h1) == brk_bits);
            if (!enable)
                run_ff <= 4'h0;
            else if (sample)
            begin
                if (line_ff)
                    run_ff <= 4'h0;
                else if (run_ff != `URES_RUN_MAX)
                    run_ff <= run_ff + 4'h1;
            end
        end
    end
endmodule // ures_rx

// [sim/ures_monitor.sv]
// Assertion checker for the receive error status block
`timescale 1ns/1ns
module ures_monitor (
    // Clock and reset
    input wire        CORE_CLK,
    input wire        ARST_N,
    // Bus handshakes
    input wire        S_AXI_AWREADY,
    input wire        S_AXI_BVALID,
    input wire        S_AXI_BREADY,
    input wire        S_AXI_ARREADY,
    input wire        S_AXI_RVALID,
    input wire        S_AXI_RREADY,
    // Interrupts and tick
    input wire        RX_INT_1,
    input wire        IRQ,
    input wire        TIMER_TICK
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // A write just committed
    sequence s_wr;
        $past(S_AXI_BVALID);
    endsequence
    property p_tick; TIMER_TICK |=> !TIMER_TICK [*3]; endproperty
    a_tick: assert property (p_tick) else $error("tick too soon");
    property p_int; $fell(RX_INT_1) |-> s_wr; endproperty
    a_int: assert property (p_int) else $error("int fell alone");
    property p_irq; $fell(IRQ) |-> s_wr; endproperty
    a_irq: assert property (p_irq) else $error("irq fell alone");
    property p_aw; S_AXI_BVALID |-> !S_AXI_AWREADY; endproperty
    a_aw: assert property (p_aw) else $error("aw open");
    property p_ar; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_ar: assert property (p_ar) else $error("ar open");
    property p_b; $rose(S_AXI_BVALID) && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
    a_b: assert property (p_b) else $error("b stuck");
    property p_r; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
    a_r: assert property (p_r) else $error("r stuck");
    property p_arb; $fell(S_AXI_RVALID) |=> S_AXI_ARREADY; endproperty
    a_arb: assert property (p_arb) else $error("ar late");
endmodule // ures_monitor
bind ures_top ures_monitor ures_monitor_i (.*);

// [sim/ures_tx_model.sv]
// Remote serial transmitter driving one receive line
`timescale 1ns/1ns
module ures_tx_model (
    // Clock and line
    input wire clk,
    output reg line
);
    initial line = 1'b1;
    task send(input [7:0] d, input s, input integer p);
        integer   i;
        reg [9:0] f;
        begin
            f = {s, d, 1'b0};
            for (i = 0; i < 12 * p; i = i + 1)
            begin
                @(posedge clk);
                line <= (i < 10 * p) ? f[i / p] : 1'b1;
            end
        end
    endtask
endmodule // ures_tx_model

// [sim/test_ures_top.sv]
// Self-checking bench for the receive error status block
`timescale 1ns/1ns
`include "ures_regs.vh"
module test_ures_top;
    reg         CORE_CLK, ARST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
    reg         S_AXI_ARVALID, S_AXI_RREADY, a, w, d;
    reg  [12:0] S_AXI_AWADDR, S_AXI_ARADDR;
    reg  [31:0] S_AXI_WDATA, rd;
    reg  [1:0]  rs;
    reg  [16:0] rows [0:4];
    wire [2:0]  S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
    wire [3:0]  S_AXI_WSTRB = 4'h1;
    wire        RX_LINE_0 = 1'b1;
    wire        RX_LINE_1, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    wire        S_AXI_RVALID, RX_INT_0, RX_INT_1, IRQ, TIMER_TICK;
    wire [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    wire [31:0] S_AXI_RDATA;
    integer     num_errors = 0, samples_checked = 0, cyc = 0, i, n;
    ures_top ures_top_i (.*);
    ures_tx_model ures_tx_model_i (.clk(CORE_CLK), .line(RX_LINE_1));
    task chk(input [31:0] g, input [31:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e)
            begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wr(input [10:0] x, input [7:0] v);
        begin
            @(posedge CORE_CLK);
            S_AXI_AWADDR <= {x, 2'h0};
            S_AXI_WDATA <= {24'h00_0000, v};
            {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
            d = 0;
            while (!d)
            begin
                @(negedge CORE_CLK);
                a = S_AXI_AWVALID & S_AXI_AWREADY;
                w = S_AXI_WVALID & S_AXI_WREADY;
                {d, rs} = {S_AXI_BVALID, S_AXI_BRESP};
                @(posedge CORE_CLK);
                if (a) S_AXI_AWVALID <= 1'b0;
                if (w) S_AXI_WVALID <= 1'b0;
                if (d) S_AXI_BREADY <= 1'b0;
            end
        end
    endtask
    task rc(input [10:0] x, input [7:0] e);
        begin
            @(posedge CORE_CLK);
            S_AXI_ARADDR <= {x, 2'h0};
            {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
            d = 0;
            while (!d)
            begin
                @(negedge CORE_CLK);
                a = S_AXI_ARVALID & S_AXI_ARREADY;
                {d, rs, rd} = {S_AXI_RVALID, S_AXI_RRESP, S_AXI_RDATA};
                @(posedge CORE_CLK);
                if (a) S_AXI_ARVALID <= 1'b0;
                if (d) S_AXI_RREADY <= 1'b0;
            end
            chk(rd, {24'h00_0000, e});
        end
    endtask
    // Interrupt lines sampled mid-cycle, idle port 0 stays quiet
    task sc(input [1:0] e);
        begin
            @(negedge CORE_CLK);
            chk({29'h0000_0000, RX_INT_0, RX_INT_1, IRQ}, {29'h0000_0000, 1'b0, e});
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial
    begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            give_verdict;
        end
    end
    initial
    begin
        {ARST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 58'h000_0000_0000_0000;
        // Data, stop bit, expected status
        rows[0] = {8'h55, 1'h1, 8'h00};
        rows[1] = {8'hA3, 1'h0, 8'h08};
        rows[2] = {8'hC0, 1'h1, 8'h00};
        rows[3] = {8'h80, 1'h1, 8'h04};
        rows[4] = {8'h00, 1'h0, 8'h0C};
        repeat (4) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        rc(`URES_IDX_STAT1, 8'h00);
        rc(`URES_IDX_SCR, 8'h00);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`URES_IDX_SCR, {4'h0, i[1:0], 2'h0});
            repeat (64) @(posedge CORE_CLK);
            n = 0;
            repeat (128) @(negedge CORE_CLK) n = n + TIMER_TICK;
            chk(n, (i == 3) ? 0 : 128 >> (2 + 2 * i));
        end
        wr(`URES_IDX_SCR, 8'h00);
        wr(`URES_IDX_BAUD, 8'hFF);
        wr(`URES_IDX_CTRL1, 8'h05);
        repeat (1100) @(posedge CORE_CLK);
        for (i = 0; i < 5; i = i + 1)
        begin
            ures_tx_model_i.send(rows[i][16:9], rows[i][8], 64);
            rc(`URES_IDX_STAT1, rows[i][7:0]);
            rc(`URES_IDX_DATA1, rows[i][16:9]);
            wr(`URES_IDX_STAT1, 8'h00);
            wr(`URES_IDX_CTRL1, 8'h05);
        end
        ures_tx_model_i.send(8'h5A, 1'b1, 64);
        ures_tx_model_i.send(8'h3C, 1'b1, 64);
        rc(`URES_IDX_STAT1, 8'h02);
        rc(`URES_IDX_DATA1, 8'h3C);
        sc(2'h2);
        wr(`URES_IDX_CTRL1, 8'h05);
        sc(2'h0);
        wr(`URES_IDX_STAT1, 8'h03);
        rc(`URES_IDX_STAT1, 8'h03);
        sc(2'h2);
        wr(`URES_IDX_IRQ_MASK, 8'h08);
        sc(2'h3);
        wr(`URES_IDX_IRQ_STAT, 8'h0F);
        sc(2'h2);
        wr(`URES_IDX_STAT1, 8'h01);
        sc(2'h0);
        wr(`URES_IDX_CTRL1, 8'h07);
        ures_tx_model_i.send(8'h80, 1'b1, 64);
        rc(`URES_IDX_STAT1, 8'h01);
        rc(`URES_IDX_CTRL1, 8'h1F);
        wr(`URES_IDX_CTRL1, 8'h07);
        ures_tx_model_i.send(8'h00, 1'b0, 64);
        rc(`URES_IDX_STAT1, 8'h05);
        sc(2'h3);
        ARST_N <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        rc(`URES_IDX_STAT1, 8'h00);
        sc(2'h0);
        wr(11'h7FF, 8'h00);
        chk({30'h0000_0000, rs}, 32'h0000_0002);
        rc(11'h7FF, 8'h00);
        chk({30'h0000_0000, rs}, 32'h0000_0002);
        give_verdict;
    end
endmodule // test_ures_top
